// File: pkg/dli_defs.vh
// Purpose: Register indices, field positions and reset values of the
//          die link initiator status and control block.
// Assumes: Avalon word index = register index; byte address = 4 * index.
// Notes:   Definitions only.
`ifndef DLI_DEFS_VH
`define DLI_DEFS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define DLI_IDX_CTRL0     3'h0
`define DLI_IDX_CTRL1     3'h1
`define DLI_IDX_ERRST     3'h2
`define DLI_IDX_STAT1     3'h3

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DLI_C0_ENABLE     7
`define DLI_C0_WIDTH8     6
`define DLI_C1_IRQ_EN     7
`define DLI_E_SUMMARY     7
`define DLI_E_ACKLINE     6
`define DLI_E_CANCEL      5
`define DLI_E_WAITEXP     4
`define DLI_E_TGTERR      3
`define DLI_E_PARITY      2
`define DLI_S1_TIRQ       7
`define DLI_S1_BUSY       6

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define DLI_RST_CTRL0     8'h00
`define DLI_RST_CTRL1     8'h00
`define DLI_RST_ERRST     8'h00
`define DLI_RST_STAT1     8'h00
`define DLI_RST_ENABLE    1'b0
`define DLI_RST_LIMIT     4'h0
`define DLI_RST_DIV       2'h0
`define DLI_RD_ZERO       32'h00000000
`define DLI_LANES_8       8'hFF
`define DLI_LANES_4       8'h0F

`endif

// File: core/dli_sync.v
// Purpose: Two flip-flop synchroniser for one level from a pin.
// Assumes: Single clock mclk, asynchronous active-low reset.
// Notes:   First stage is read only by the second stage.
`default_nettype none

module dli_sync
(
	input  wire mclk,
	input  wire arst_n,
	input  wire clk_en,
	input  wire din,
	output reg  dout
);

	reg meta;

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta <= 1'b0;
			dout <= 1'b0;
		end
		else if (clk_en)
		begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule // dli_sync

`default_nettype wire

// File: core/dli_wait_timer.v
// Purpose: Counts link clock cycles after the last transfer cycle
//          and flags an expired acknowledge wait.
// Assumes: link_tick marks one interface clock cycle.
// Notes:   limit wait states are allowed; the next tick expires.
`default_nettype none

module dli_wait_timer
(
	input  wire       mclk,
	input  wire       arst_n,
	input  wire       clk_en,
	input  wire       arm,
	input  wire       ack,
	input  wire       link_tick,
	input  wire [3:0] limit,
	output reg        expired
);

	reg       waiting;
	reg [3:0] count;

	// ----------------------------------------------------------------
	// Wait counter
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			waiting <= 1'b0;
			count   <= 4'h0;
			expired <= 1'b0;
		end
		else if (clk_en)
		begin
			expired <= 1'b0;
			if (arm)
			begin
				waiting <= 1'b1;
				count   <= 4'h0;
			end
			else if (waiting && ack)
			begin
				waiting <= 1'b0;
			end
			else if (waiting && link_tick)
			begin
				// Zero limit expires on the first tick without ack
				if (count == limit)
				begin
					waiting <= 1'b0;
					expired <= 1'b1;
				end
				else
				begin
					count <= count + 4'h1;
				end
			end
		end
	end

endmodule // dli_wait_timer

`default_nettype wire

// File: core/dli_status_ctrl.v
// Purpose: Control and status registers of the die link initiator:
//          enable lock, interrupt enable, acknowledge wait limit,
//          error flags, busy and target interrupt mirror.
// Assumes: Avalon-MM slave, word index addressing, 8-bit registers
//          in the low byte; sequencer and pins as listed below.
// Notes:   clk_en low freezes all state including the bus answer.
//
// Operation
// - Control bit 7 enables target interrupt.
// - Timeout after limit cycles sets timeout flag.
// - Wait limit write-once, special modes always writable.
// - Zero limit: ack directly after last cycle.
// - Nonzero limit allows that many wait states.
// - Enable set locks write-once bits until reset.
// - Summary flag set by any error flag.
// - Summary unmasked; write one clears it.
// - Ack cycle line not high sets fault.
// - Pending summary cancels transaction, sends idle.
// - Detected timeout sets timeout flag bit 4.
// - Target error at ack sets flag.
// - Parity error sets parity fault flag.
// - Received parity bits captured in bits 1:0.
// - Summary clear also clears five flags.
// - Target interrupt flag follows pin level.
// - Busy bit shows transaction in progress.
// - Enable write-once in normal mode.
//
// The Avalon-MM interface to the registers was left to the implementer.
`default_nettype none
`include "dli_defs.vh"

module dli_status_ctrl
(
	input  wire        mclk,
	input  wire        arst_n,
	input  wire        clk_en,
	input  wire        special_mode,
	input  wire [2:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [3:0]  avs_byteenable,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire        xfer_request,
	input  wire        xfer_last_cycle,
	input  wire        link_tick,
	input  wire        ack_cycle,
	input  wire [7:0]  ack_lines,
	input  wire        ack_target_error,
	input  wire [1:0]  ack_parity,
	input  wire        parity_error,
	input  wire        target_irq_pin,
	output reg         xfer_go,
	output reg         xfer_cancel,
	output wire        xfer_timeout,
	output reg         cfg_link_enable,
	output reg         cfg_width8,
	output reg  [1:0]  cfg_clk_div,
	output reg  [3:0]  cfg_wait_limit,
	output reg         irq_pin_pulldown,
	output reg         irq
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function [7:0] lane_mask;
		input wide;
		begin
			lane_mask = wide ? `DLI_LANES_8 : `DLI_LANES_4;
		end
	endfunction

	function [31:0] low_byte;
		input [7:0] val;
		begin
			low_byte = {24'h000000, val};
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg        target_irq_enable;
	reg        error_summary_flag;
	reg        ack_line_fault_flag;
	reg        cancelled_flag;
	reg        wait_expired_flag;
	reg        target_error_flag;
	reg        parity_fault_flag;
	reg        rx_parity_hi;
	reg        rx_parity_lo;
	reg        initiator_busy;
	wire       target_irq_flag;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire       bus_req;
	wire       wr_take;
	wire       wr_lane;
	wire       locked;
	wire       wr_ctrl0;
	wire       wr_ctrl1;
	wire       wr_errst;
	wire       err_clear;
	wire [7:0] wbyte;

	assign bus_req  = avs_read | avs_write;
	assign wr_take  = avs_write & ~avs_waitrequest;
	assign wr_lane  = wr_take & avs_byteenable[0];
	assign wbyte    = avs_writedata[7:0];
	// Lock holds once enable is set, except in special modes
	assign locked   = cfg_link_enable & ~special_mode;
	assign wr_ctrl0 = wr_lane & (avs_address == `DLI_IDX_CTRL0);
	assign wr_ctrl1 = wr_lane & (avs_address == `DLI_IDX_CTRL1);
	assign wr_errst = wr_lane & (avs_address == `DLI_IDX_ERRST);
	assign err_clear = wr_errst & wbyte[`DLI_E_SUMMARY];

	// ----------------------------------------------------------------
	// Pin synchroniser and wait timer
	// ----------------------------------------------------------------
	dli_sync u_irq_sync
	(
		.mclk   (mclk),
		.arst_n (arst_n),
		.clk_en (clk_en),
		.din    (target_irq_pin),
		.dout   (target_irq_flag)
	);

	// Armed only while busy, so a stray last-cycle pulse is ignored
	dli_wait_timer u_wait
	(
		.mclk      (mclk),
		.arst_n    (arst_n),
		.clk_en    (clk_en),
		.arm       (xfer_last_cycle & initiator_busy),
		.ack       (ack_cycle),
		.link_tick (link_tick),
		.limit     (cfg_wait_limit),
		.expired   (xfer_timeout)
	);

	// ----------------------------------------------------------------
	// Error events
	// ----------------------------------------------------------------
	wire ev_ackline;
	wire ev_cancel;
	wire ev_waitexp;
	wire ev_tgterr;
	wire ev_parity;
	wire ev_any;
	wire start_ok;
	wire [7:0] used_lanes;

	// Ack lines are judged only on the lanes in use
	assign used_lanes = lane_mask(cfg_width8);
	assign ev_ackline = ack_cycle & ((ack_lines & used_lanes) != used_lanes);
	assign ev_cancel  = xfer_request & cfg_link_enable & error_summary_flag;
	assign ev_waitexp = xfer_timeout;
	assign ev_tgterr  = ack_cycle & ack_target_error;
	assign ev_parity  = parity_error;
	assign ev_any     = ev_ackline | ev_cancel | ev_waitexp | ev_tgterr | ev_parity;
	assign start_ok   = xfer_request & cfg_link_enable & ~error_summary_flag & ~initiator_busy;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg_link_enable   <= `DLI_RST_ENABLE;
			cfg_width8        <= 1'b0;
			cfg_clk_div       <= `DLI_RST_DIV;
			cfg_wait_limit    <= `DLI_RST_LIMIT;
			target_irq_enable <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_ctrl0 && !locked)
			begin
				cfg_link_enable <= wbyte[`DLI_C0_ENABLE];
				cfg_width8      <= wbyte[`DLI_C0_WIDTH8];
				cfg_clk_div     <= wbyte[1:0];
			end
			// Interrupt enable stays writable after the lock
			if (wr_ctrl1)
			begin
				target_irq_enable <= wbyte[`DLI_C1_IRQ_EN];
				if (!locked)
				begin
					cfg_wait_limit <= wbyte[3:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Error flags: a new event wins over a clear in the same cycle
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			error_summary_flag  <= 1'b0;
			ack_line_fault_flag <= 1'b0;
			cancelled_flag      <= 1'b0;
			wait_expired_flag   <= 1'b0;
			target_error_flag   <= 1'b0;
			parity_fault_flag   <= 1'b0;
			rx_parity_hi        <= 1'b0;
			rx_parity_lo        <= 1'b0;
		end
		else if (clk_en)
		begin
			error_summary_flag  <= (error_summary_flag & ~err_clear) | ev_any;
			ack_line_fault_flag <= (ack_line_fault_flag & ~err_clear) | ev_ackline;
			cancelled_flag      <= (cancelled_flag & ~err_clear) | ev_cancel;
			wait_expired_flag   <= (wait_expired_flag & ~err_clear) | ev_waitexp;
			target_error_flag   <= (target_error_flag & ~err_clear) | ev_tgterr;
			parity_fault_flag   <= (parity_fault_flag & ~err_clear) | ev_parity;
			// Parity bits survive a summary clear; only an ack updates them
			if (ack_cycle)
			begin
				rx_parity_hi <= ack_parity[1];
				rx_parity_lo <= ack_parity[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Transaction start, cancel and busy
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			initiator_busy <= 1'b0;
			xfer_go        <= 1'b0;
			xfer_cancel    <= 1'b0;
		end
		else if (clk_en)
		begin
			// A request while disabled, or while busy with no pending summary, is dropped without a flag
			xfer_go     <= start_ok;
			xfer_cancel <= ev_cancel;
			if (start_ok)
			begin
				initiator_busy <= 1'b1;
			end
			else if (ack_cycle || xfer_timeout)
			begin
				initiator_busy <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt and pull-down outputs
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq              <= 1'b0;
			irq_pin_pulldown <= 1'b0;
		end
		else if (clk_en)
		begin
			irq              <= error_summary_flag | (target_irq_flag & target_irq_enable);
			// Pull-down only while the link owns the pin
			irq_pin_pulldown <= cfg_link_enable;
		end
	end

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	reg [7:0] rd_byte;

	always @*
	begin
		rd_byte = 8'h00;
		case (avs_address)
			`DLI_IDX_CTRL0:
			begin
				rd_byte = {cfg_link_enable, cfg_width8, 4'h0, cfg_clk_div};
			end
			`DLI_IDX_CTRL1:
			begin
				rd_byte = {target_irq_enable, 3'h0, cfg_wait_limit};
			end
			`DLI_IDX_ERRST:
			begin
				rd_byte = {error_summary_flag, ack_line_fault_flag, cancelled_flag,
					wait_expired_flag, target_error_flag, parity_fault_flag,
					rx_parity_hi, rx_parity_lo};
			end
			`DLI_IDX_STAT1:
			begin
				rd_byte = {target_irq_flag, initiator_busy, 6'h00};
			end
			default:
			begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Avalon answer: one wait cycle, read data registered
	// ----------------------------------------------------------------
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= `DLI_RD_ZERO;
		end
		else if (clk_en)
		begin
			if (avs_waitrequest)
			begin
				avs_waitrequest <= ~bus_req;
				// Read data reflect the registers at the edge that drops waitrequest, one cycle before the taking edge
				if (avs_read)
				begin
					avs_readdata <= low_byte(rd_byte);
				end
			end
			else
			begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

endmodule // dli_status_ctrl

`default_nettype wire

// File: verif/dli_status_ctrl_chk.sv
// Purpose: Port-level assertions for dli_status_ctrl.
// Assumes: clk_en is held high.
// Notes:   Bound to every instance of the design.
`default_nettype none

module dli_status_ctrl_chk
(
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        special_mode,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        xfer_request,
	input wire logic        link_tick,
	input wire logic        ack_cycle,
	input wire logic        xfer_go,
	input wire logic        xfer_cancel,
	input wire logic        xfer_timeout,
	input wire logic        cfg_link_enable,
	input wire logic        cfg_width8,
	input wire logic [1:0]  cfg_clk_div,
	input wire logic [3:0]  cfg_wait_limit,
	input wire logic        irq_pin_pulldown,
	input wire logic        irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	wait_drop_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest did not drop");
	wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	go_cause_a: assert property (xfer_go |-> $past(xfer_request) && !xfer_cancel)
		else $error("start without request");
	cancel_irq_a: assert property (xfer_cancel |-> irq)
		else $error("cancel without pending error");
	expiry_tick_a: assert property (xfer_timeout |-> $past(link_tick) && !$past(ack_cycle))
		else $error("timeout not after an unanswered tick");
	expiry_irq_a: assert property (xfer_timeout |-> ##[1:3] irq)
		else $error("timeout did not raise irq");
	lock_hold_a: assert property (cfg_link_enable && !special_mode |=>
		$stable({cfg_link_enable, cfg_width8, cfg_clk_div, cfg_wait_limit}))
		else $error("locked field changed");
	pull_down_a: assert property (1'b1 |=> irq_pin_pulldown == $past(cfg_link_enable))
		else $error("pull-down does not follow enable");
endmodule // dli_status_ctrl_chk

bind dli_status_ctrl dli_status_ctrl_chk u_chk (.mclk, .arst_n, .special_mode, .avs_read,
	.avs_write, .avs_waitrequest, .xfer_request, .link_tick, .ack_cycle, .xfer_go,
	.xfer_cancel, .xfer_timeout, .cfg_link_enable, .cfg_width8, .cfg_clk_div,
	.cfg_wait_limit, .irq_pin_pulldown, .irq);

`default_nettype wire

// File: verif/dli_target_model.sv
// Purpose: Target die: answers transfers, drives its interrupt line.
// Assumes: waits of 15 means no answer within any limit below 15.
// Notes:   Lines toggle outside the ack cycle.
`default_nettype none

module dli_target_model
(
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       xfer_go,
	input  wire logic       xfer_timeout,
	input  wire logic [3:0] waits,
	input  wire logic       bad_line,
	input  wire logic       tgt_err,
	input  wire logic       par_err,
	input  wire logic [1:0] par_bits,
	input  wire logic       irq_level,
	output logic            xfer_last_cycle,
	output logic            link_tick,
	output logic            ack_cycle,
	output logic [7:0]      ack_lines,
	output logic            ack_target_error,
	output logic [1:0]      ack_parity,
	output logic            parity_error,
	output logic            target_irq_pin
);
	logic       on;
	logic [3:0] cnt;

	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{on, cnt, xfer_last_cycle, link_tick, ack_cycle, parity_error} <= '0;
			{ack_lines, ack_target_error, ack_parity, target_irq_pin} <= '0;
		end
		else
		begin
			ack_lines        <= ~ack_lines;
			ack_target_error <= ~ack_target_error;
			ack_parity       <= ~ack_parity;
			ack_cycle        <= 1'b0;
			parity_error     <= 1'b0;
			xfer_last_cycle  <= xfer_go;
			link_tick        <= on;
			target_irq_pin   <= irq_level;
			if (xfer_go)
			begin
				on  <= 1'b1;
				cnt <= 4'h0;
			end
			else if (on)
			begin
				cnt <= cnt + 4'h1;
				if (cnt == waits)
				begin
					on               <= 1'b0;
					ack_cycle        <= 1'b1;
					ack_lines        <= bad_line ? 8'hF7 : 8'hFF;
					ack_target_error <= tgt_err;
					ack_parity       <= par_bits;
					parity_error     <= par_err;
				end
			end
			if (xfer_timeout)
				on <= 1'b0;
		end
	end
endmodule // dli_target_model

`default_nettype wire

// File: verif/dli_status_ctrl_tb.sv
// Purpose: Self-checking bench for dli_status_ctrl.
// Assumes: Four-bit link width; clk_en and byteenable held on.
// Notes:   Register model kept in integers.
`default_nettype none

module dli_status_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 1'b0, arst_n = 1'b0, special_mode = 1'b0;
	logic        avs_read = 1'b0, avs_write = 1'b0, xfer_request = 1'b0;
	logic [2:0]  avs_address = 3'h0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  t_waits = 4'h0;
	logic        t_bad = 1'b0, t_terr = 1'b0, t_perr = 1'b0, t_irq = 1'b0;
	logic [1:0]  t_par = 2'h0;
	wire  [31:0] avs_readdata;
	wire  [7:0]  ack_lines;
	wire  [1:0]  ack_parity;
	wire  [3:0]  cfg_wait_limit;
	wire         avs_waitrequest, xfer_last_cycle, link_tick, ack_cycle, ack_target_error;
	wire         parity_error, target_irq_pin, xfer_go, xfer_cancel, xfer_timeout, irq;
	int          n_fail = 0, check_count = 0, cyc = 0, i;
	int          m_c0 = 0, m_c1 = 0, m_err = 0, m_tirq = 0;
	integer      seed = 32'h535AB650;
	logic [31:0] rd, r;

	dli_status_ctrl dut (.mclk, .arst_n, .clk_en(1'b1), .special_mode, .avs_address,
		.avs_read, .avs_write, .avs_byteenable(4'hF), .avs_writedata, .avs_readdata,
		.avs_waitrequest, .xfer_request, .xfer_last_cycle, .link_tick, .ack_cycle,
		.ack_lines, .ack_target_error, .ack_parity, .parity_error, .target_irq_pin,
		.xfer_go, .xfer_cancel, .xfer_timeout, .cfg_link_enable(), .cfg_width8(),
		.cfg_clk_div(), .cfg_wait_limit, .irq_pin_pulldown(), .irq);
	dli_target_model u_tgt (.mclk, .arst_n, .xfer_go, .xfer_timeout, .waits(t_waits),
		.bad_line(t_bad), .tgt_err(t_terr), .par_err(t_perr), .par_bits(t_par),
		.irq_level(t_irq), .xfer_last_cycle, .link_tick, .ack_cycle, .ack_lines,
		.ack_target_error, .ack_parity, .parity_error, .target_irq_pin);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= {24'h000000, d};
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input int a, input int d);
		int lk;
		lk = m_c0[7] && !special_mode;
		bus(1'b1, a[2:0], d[7:0]);
		case (a)
			0: if (!lk) m_c0 = d & 8'hC3;
			1: m_c1 = lk ? (d & 8'h80) | (m_c1 & 8'h0F) : d & 8'h8F;
			2: if (d[7]) m_err = m_err & 8'h03;
			default: ;
		endcase
	endtask

	task automatic rdchk(input int a);
		bus(1'b0, a[2:0], 8'h00);
		chk("register", (a == 0) ? m_c0 : (a == 1) ? m_c1 : (a == 2) ? m_err :
			(a == 3) ? m_tirq * 128 : 0, rd);
	endtask

	task automatic xact(input int w, input logic bad, input logic te, input logic pe);
		int lim, pend, hit;
		lim  = m_c1 & 8'h0F;
		pend = m_err[7];
		r    = $random(seed);
		@(posedge mclk);
		t_waits      <= (w > lim) ? 4'hF : w[3:0];
		t_bad        <= bad;
		t_terr       <= te;
		t_perr       <= pe;
		t_par        <= r[1:0];
		xfer_request <= 1'b1;
		@(posedge mclk);
		xfer_request <= 1'b0;
		@(posedge mclk);
		chk("xfer_cancel", pend, xfer_cancel);
		chk("xfer_go", !pend, xfer_go);
		if (pend)
			m_err = m_err | 8'hA0;
		else
		begin
			if (w > 1)
			begin
				bus(1'b0, 3'h3, 8'h00);
				chk("busy", m_tirq * 128 + 8'h40, rd);
			end
			hit = 0;
			for (int k = 0; k < 40 && hit == 0; k++)
			begin
				@(posedge mclk);
				hit = (ack_cycle === 1'b1) ? 1 : (xfer_timeout === 1'b1) ? 2 : 0;
			end
			chk("ack or timeout", (w > lim) ? 2 : 1, hit);
			if (w > lim)
				m_err = m_err | 8'h90;
			else
				m_err = (m_err & 8'hFC) | r[1:0] | (bad ? 8'hC0 : 0) | (te ? 8'h88 : 0)
					| (pe ? 8'h84 : 0);
		end
		repeat (3) @(posedge mclk);
		rdchk(2);
		$display("test transaction %0d done", w);
	endtask

	// ----------------------------------------------------------------
	// Clock, timeout and sequence
	// ----------------------------------------------------------------
	initial
	begin
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			n_fail++;
			summarize();
		end
	end

	initial
	begin
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		for (i = 0; i < 8; i++)
			rdchk(i);
		wr(5, 8'hFF);
		rdchk(5);
		wr(1, 8'h83);
		wr(0, 8'h80);
		wr(1, 8'h05);
		wr(0, 8'h00);
		for (i = 0; i < 3; i++)
			rdchk(i);
		chk("wait limit", 4'h3, cfg_wait_limit);
		$display("test config done");
		for (i = 0; i < 15; i++)
		begin
			r = $random(seed);
			xact(i % 5, r[0], r[1], r[2]);
			if (i % 3 != 2)
				wr(2, 8'h80);
		end
		xact(4, 1'b0, 1'b0, 1'b0);
		wr(2, 8'h00);
		rdchk(2);
		wr(2, 8'h80);
		rdchk(2);
		t_irq  <= 1'b1;
		m_tirq = 1;
		repeat (4) @(posedge mclk);
		rdchk(3);
		chk("irq", m_err[7], irq);
		wr(1, 8'h80);
		repeat (2) @(posedge mclk);
		chk("irq", 1'b1, irq);
		wr(1, 8'h00);
		repeat (2) @(posedge mclk);
		chk("irq", m_err[7], irq);
		t_irq  <= 1'b0;
		m_tirq = 0;
		repeat (4) @(posedge mclk);
		rdchk(3);
		$display("test interrupt done");
		special_mode <= 1'b1;
		@(posedge mclk);
		wr(1, 8'h80);
		@(posedge mclk);
		chk("wait limit", 4'h0, cfg_wait_limit);
		xact(0, 1'b0, 1'b0, 1'b0);
		xact(1, 1'b0, 1'b0, 1'b0);
		wr(2, 8'h80);
		wr(0, 8'h00);
		rdchk(0);
		wr(0, 8'h80);
		wr(1, 8'h8A);
		$display("test special mode done");
		arst_n       <= 1'b0;
		special_mode <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		m_c0  = 0;
		m_c1  = 0;
		m_err = 0;
		for (i = 0; i < 4; i++)
			rdchk(i);
		wr(1, 8'h05);
		rdchk(1);
		$display("test reset done");
		summarize();
	end
endmodule // dli_status_ctrl_tb

`default_nettype wire
